// file: hdl/tcc_core.sv
/*
 * Eight-channel 16-bit input-capture/output-compare timer with APB register access.
 * Assumes channel pins are asynchronous and are synchronised here; APB on mclk_i.
 */
// The APB interface to the registers was left to the implementer.
//
// Behaviour
// - Edge field: off, rising, falling, both
// - Channel flag interrupts only when enabled
// - Overflow interrupt gated by its enable
// - Compare 7 clears counter when enabled
// - Compare 7 at zero holds counter zero
// - Compare 7 at max suppresses overflow flag
// - Prescaler divides bus clock by 2^select
// - New prescale applies when stages zero
// - Capture or compare event sets channel flag
// - Write one clears channel flag
// - Fast clear on channel read (capture) or write (compare)
// - Fast clear overflow on counter access
// - Counter wrap to zero sets overflow
// - Overflow bit written one clears it
// - Capture copies counter on chosen edge
// - Compare match triggers output action
// - Channel writes ignored in capture mode
// - Channel registers reset to zero
// - Run enable low halts counter, prescaler
// - Action: disconnect, toggle, low, high
`timescale 1ns/10ps
`include "tcc_regs.svh"

module tcc_core #(
    parameter int CH_N = 8,
    parameter int CNT_W = 16,
    parameter int AW = 8
) (
    input wire logic mclk_i,                       // Bus clock, 250 MHz
    input wire logic nrst_i,                       // Async reset, active low
    input wire logic psel_i,                       // APB select
    input wire logic penable_i,                    // APB access phase
    input wire logic pwrite_i,                     // APB write
    input wire logic [AW-1:0] paddr_i,             // APB byte address
    input wire tcc_pkg::tcc_word_t pwdata_i,       // APB write data
    input wire logic [3:0] pstrb_i,                // APB byte strobes
    output tcc_pkg::tcc_word_t prdata_o,           // APB read data
    output logic pready_o,                         // APB ready
    output logic pslverr_o,                        // APB error
    input wire logic [CH_N-1:0] chan_pin_i,        // Channel input pins
    output logic [CH_N-1:0] compare_output_line_o, // Compare output levels
    output logic [CH_N-1:0] compare_output_oe_o,   // Compare pin drive enable
    output logic [CH_N-1:0] chan_irq_o,            // Channel interrupt requests
    output logic ovf_irq_o                         // Overflow interrupt request
);
    import tcc_pkg::*;

    if (CH_N != 8 || CNT_W != 16 || AW < 8) begin : g_chk
        $error("tcc_core needs 8 channels, a 16-bit counter, address width >= 8");
    end

    // Mapped register test
    function automatic logic idx_mapped(input logic [5:0] idx);
        logic ok;
        ok = 1'b0;
        if (idx == `TCC_IDX_IOSEL) begin
            ok = 1'b1;
        end else if (idx == `TCC_IDX_CNT_HI || idx == `TCC_IDX_CNT_LO) begin
            ok = 1'b1;
        end else if (idx == `TCC_IDX_CTRL1) begin
            ok = 1'b1;
        end else if (idx >= `TCC_IDX_ACT_HI && idx <= `TCC_IDX_CH_LAST) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // Pair of bits for channel n from a 16-bit control word
    function automatic logic [1:0] field2(input logic [15:0] w, input int n);
        return w[2*n +: 2];
    endfunction

    // Bus decode
    logic [5:0] idx;
    logic addr_ok;
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic ch_sel;
    logic [2:0] ch_num;
    logic ch_hi;
    logic cnt_sel;
    logic [7:0] wbyte;

    assign idx = paddr_i[7:2];
    assign addr_ok = idx_mapped(idx) && (paddr_i[1:0] == 2'b00);
    assign setup = psel_i & ~penable_i;
    assign acc = psel_i & penable_i & addr_ok;
    assign wr = acc & pwrite_i & pstrb_i[0];
    assign rd = acc & ~pwrite_i;
    assign ch_sel = (idx[5:4] == `TCC_IDX_CH_BASE);
    assign ch_num = idx[3:1];
    assign ch_hi = ~idx[0];
    assign cnt_sel = (idx == `TCC_IDX_CNT_HI) || (idx == `TCC_IDX_CNT_LO);
    assign wbyte = pwdata_i[7:0];
    assign pready_o = penable_i;

    // Software registers
    logic [7:0] iosel_q;
    logic [7:0] ctrl1_q;
    logic [15:0] act_q;
    logic [15:0] edge_q;
    logic [7:0] ien_q;
    logic [7:0] ctrl2_q;
    logic [7:0] chflag_q;
    logic tof_q;
    tcc_cnt_t cnt_q;
    tcc_cnt_t chv_q [CH_N];
    logic [7:0] wbuf_q;
    logic [7:0] rbuf_q;
    logic [CH_N-1:0] oc_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    logic run;
    logic ffc;
    logic counter_reset_on_match7;
    assign run = ctrl1_q[`TCC_RUN_BIT];
    assign ffc = ctrl1_q[`TCC_FFC_BIT];
    assign counter_reset_on_match7 = ctrl2_q[`TCC_COUNTER_RESET_ON_MATCH7_BIT];

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            iosel_q <= `TCC_RST_BYTE;
            ctrl1_q <= `TCC_RST_BYTE;
            ien_q <= `TCC_RST_BYTE;
            ctrl2_q <= `TCC_RST_BYTE;
            act_q <= `TCC_RST_WORD;
            edge_q <= `TCC_RST_WORD;
        end else if (wr) begin
            if (idx == `TCC_IDX_IOSEL) begin
                iosel_q <= wbyte;
            end else if (idx == `TCC_IDX_CTRL1) begin
                ctrl1_q <= wbyte;
            end else if (idx == `TCC_IDX_ACT_HI) begin
                act_q[15:8] <= wbyte;
            end else if (idx == `TCC_IDX_ACT_LO) begin
                act_q[7:0] <= wbyte;
            end else if (idx == `TCC_IDX_EDGE_HI) begin
                edge_q[15:8] <= wbyte;
            end else if (idx == `TCC_IDX_EDGE_LO) begin
                edge_q[7:0] <= wbyte;
            end else if (idx == `TCC_IDX_IEN) begin
                ien_q <= wbyte;
            end else if (idx == `TCC_IDX_CTRL2) begin
                ctrl2_q <= wbyte;
            end
        end
    end

    // Pin synchronisers and edge detection
    logic [CH_N-1:0] pin_s1_q;
    logic [CH_N-1:0] pin_s2_q;
    logic [CH_N-1:0] pin_prev_q;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_s1_q <= chan_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    logic [CH_N-1:0] cap_hit;
    logic [CH_N-1:0] cmp_hit;
    logic tick;

    always_comb begin
        for (int n = 0; n < CH_N; n++) begin
            tcc_edge_t em;
            logic rise;
            logic fall;
            em = tcc_edge_t'(field2(edge_q, n));
            rise = pin_s2_q[n] & ~pin_prev_q[n];
            fall = ~pin_s2_q[n] & pin_prev_q[n];
            cap_hit[n] = 1'b0;
            case (em)
                TCC_EDGE_OFF: cap_hit[n] = 1'b0;
                TCC_EDGE_RISE: cap_hit[n] = rise;
                TCC_EDGE_FALL: cap_hit[n] = fall;
                default: cap_hit[n] = rise | fall;
            endcase
            cap_hit[n] = cap_hit[n] & ~iosel_q[n];
            cmp_hit[n] = tick & iosel_q[n] & (cnt_q == chv_q[n]);
        end
    end

    tcc_prescaler #(
        .SEL_W(3)
    ) u_pre (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .run_i(run),
        .sel_i(ctrl2_q[`TCC_PR_MSB:`TCC_PR_LSB]),
        .tick_o(tick)
    );

    // Main counter
    logic match7_rst;
    assign match7_rst = counter_reset_on_match7 & cmp_hit[`TCC_MATCH7_CH];

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= `TCC_RST_WORD;
        end else if (wr && idx == `TCC_IDX_CNT_LO) begin
            cnt_q <= {wbuf_q, wbyte};
        end else if (tick) begin
            if (match7_rst) begin
                cnt_q <= `TCC_RST_WORD;
            end else begin
                cnt_q <= cnt_q + `TCC_CNT_ONE;
            end
        end
    end

    // Overflow flag; a set in the clearing cycle wins
    logic tof_set;
    logic tof_clr;
    assign tof_set = tick & (cnt_q == `TCC_CNT_MAX) & ~match7_rst;
    assign tof_clr = (wr && idx == `TCC_IDX_OVFLAG && wbyte[`TCC_TOF_BIT])
        || (acc && ffc && cnt_sel);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tof_q <= 1'b0;
        end else begin
            tof_q <= tof_set | (tof_q & ~tof_clr);
        end
    end

    // Channel flags; a set in the clearing cycle wins
    logic [7:0] ch_clr;
    always_comb begin
        ch_clr = 8'h00;
        if (wr && idx == `TCC_IDX_CHFLAG) begin
            ch_clr = wbyte;
        end
        if (acc && ffc && ch_sel) begin
            if ((rd && !iosel_q[ch_num]) || (wr && iosel_q[ch_num])) begin
                ch_clr[ch_num] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chflag_q <= `TCC_RST_BYTE;
        end else begin
            chflag_q <= (cap_hit | cmp_hit) | (chflag_q & ~ch_clr);
        end
    end

    assign chan_irq_o = chflag_q & ien_q;
    assign ovf_irq_o = tof_q & ctrl2_q[`TCC_TOI_BIT];

    // Channel capture/compare values
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int n = 0; n < CH_N; n++) begin
                chv_q[n] <= `TCC_RST_WORD;
            end
        end else begin
            for (int n = 0; n < CH_N; n++) begin
                if (cap_hit[n]) begin
                    chv_q[n] <= cnt_q;
                end else if (wr && ch_sel && !ch_hi && ch_num == 3'(n) && iosel_q[n]) begin
                    chv_q[n] <= {wbuf_q, wbyte};
                end
            end
        end
    end

    // High-byte write buffer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wbuf_q <= `TCC_RST_BYTE;
        end else if (wr && ((ch_sel && ch_hi) || idx == `TCC_IDX_CNT_HI)) begin
            wbuf_q <= wbyte;
        end
    end

    // Low byte caught with the high byte read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rbuf_q <= `TCC_RST_BYTE;
        end else if (setup && !pwrite_i && ch_sel && ch_hi) begin
            rbuf_q <= chv_q[ch_num][7:0];
        end else if (setup && !pwrite_i && idx == `TCC_IDX_CNT_HI) begin
            rbuf_q <= cnt_q[7:0];
        end
    end

    // Compare output pins
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oc_q <= '0;
        end else begin
            for (int n = 0; n < CH_N; n++) begin
                if (cmp_hit[n]) begin
                    case (tcc_act_t'(field2(act_q, n)))
                        TCC_ACT_TOGGLE: oc_q[n] <= ~oc_q[n];
                        TCC_ACT_LOW: oc_q[n] <= 1'b0;
                        TCC_ACT_HIGH: oc_q[n] <= 1'b1;
                        default: oc_q[n] <= oc_q[n];
                    endcase
                end
            end
        end
    end

    always_comb begin
        for (int n = 0; n < CH_N; n++) begin
            compare_output_oe_o[n] = iosel_q[n] & (field2(act_q, n) != TCC_ACT_NONE);
        end
    end
    assign compare_output_line_o = oc_q;

    // Read data, prepared in the setup cycle
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        if (idx == `TCC_IDX_IOSEL) begin
            rd_val = iosel_q;
        end else if (idx == `TCC_IDX_CNT_HI) begin
            rd_val = cnt_q[15:8];
        end else if (idx == `TCC_IDX_CNT_LO) begin
            rd_val = rbuf_q; // Low byte caught with the high byte
        end else if (idx == `TCC_IDX_CTRL1) begin
            rd_val = ctrl1_q;
        end else if (idx == `TCC_IDX_ACT_HI) begin
            rd_val = act_q[15:8];
        end else if (idx == `TCC_IDX_ACT_LO) begin
            rd_val = act_q[7:0];
        end else if (idx == `TCC_IDX_EDGE_HI) begin
            rd_val = edge_q[15:8];
        end else if (idx == `TCC_IDX_EDGE_LO) begin
            rd_val = edge_q[7:0];
        end else if (idx == `TCC_IDX_IEN) begin
            rd_val = ien_q;
        end else if (idx == `TCC_IDX_CTRL2) begin
            rd_val = ctrl2_q;
        end else if (idx == `TCC_IDX_CHFLAG) begin
            rd_val = chflag_q;
        end else if (idx == `TCC_IDX_OVFLAG) begin
            rd_val = {tof_q, 7'h00};
        end else if (ch_sel && ch_hi) begin
            rd_val = chv_q[ch_num][15:8];
        end else if (ch_sel) begin
            rd_val = rbuf_q;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= (addr_ok && !pwrite_i) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            slverr_q <= ~addr_ok;
        end
    end

    assign prdata_o = prdata_q;
    assign pslverr_o = penable_i & slverr_q;
endmodule

// file: pkg/tcc_regs.svh
/*
 * Register indices, field positions and reset values of the capture/compare timer.
 * Assumes APB with 32-bit data; each 8-bit register sits in the low byte of one word
 * at byte address four times its index.
 */
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// Register indices (byte address = index * 4)
`define TCC_IDX_IOSEL     6'h00
`define TCC_IDX_CNT_HI    6'h04
`define TCC_IDX_CNT_LO    6'h05
`define TCC_IDX_CTRL1     6'h06
`define TCC_IDX_ACT_HI    6'h08
`define TCC_IDX_ACT_LO    6'h09
`define TCC_IDX_EDGE_HI   6'h0a
`define TCC_IDX_EDGE_LO   6'h0b
`define TCC_IDX_IEN       6'h0c
`define TCC_IDX_CTRL2     6'h0d
`define TCC_IDX_CHFLAG    6'h0e
`define TCC_IDX_OVFLAG    6'h0f
`define TCC_IDX_CH_BASE   2'h1
`define TCC_IDX_CH_LAST   6'h1f

// Field positions
`define TCC_RUN_BIT       7
`define TCC_FFC_BIT       4
`define TCC_TOI_BIT       7
`define TCC_COUNTER_RESET_ON_MATCH7_BIT      3
`define TCC_PR_MSB        2
`define TCC_PR_LSB        0
`define TCC_TOF_BIT       7
`define TCC_MATCH7_CH     7

// Values
`define TCC_RST_BYTE      8'h00
`define TCC_RST_WORD      16'h0000
`define TCC_CNT_MAX       16'hffff
`define TCC_CNT_ONE       16'h0001
`define TCC_PRE_ZERO      7'h00
`define TCC_PRE_ONE       7'h01

`endif

// file: pkg/tcc_pkg.sv
/*
 * Types shared by the capture/compare timer files.
 * Assumes tcc_regs.svh supplies offsets and field positions.
 */
package tcc_pkg;
    typedef logic [31:0] tcc_word_t;
    typedef logic [15:0] tcc_cnt_t;
    typedef logic [2:0] tcc_presel_t;

    typedef enum logic [1:0] {
        TCC_EDGE_OFF = 2'b00,
        TCC_EDGE_RISE = 2'b01,
        TCC_EDGE_FALL = 2'b10,
        TCC_EDGE_ANY = 2'b11
    } tcc_edge_t;

    typedef enum logic [1:0] {
        TCC_ACT_NONE = 2'b00,
        TCC_ACT_TOGGLE = 2'b01,
        TCC_ACT_LOW = 2'b10,
        TCC_ACT_HIGH = 2'b11
    } tcc_act_t;
endpackage

// file: hdl/tcc_prescaler.sv
/*
 * Bus clock prescaler producing a one-cycle tick every 2^select cycles.
 * Assumes select comes from a register on the same clock; run halts it.
 */
`timescale 1ns/10ps
`include "tcc_regs.svh"

module tcc_prescaler #(
    parameter int SEL_W = 3
) (
    input wire logic mclk_i,                 // Bus clock
    input wire logic nrst_i,                 // Async reset, active low
    input wire logic run_i,                  // Timer running
    input wire tcc_pkg::tcc_presel_t sel_i,  // Requested division select
    output logic tick_o                      // One-cycle count pulse
);
    import tcc_pkg::*;

    if (SEL_W != 3) begin : g_chk
        $error("tcc_prescaler supports only a 3-bit select");
    end

    logic [6:0] stage_q;
    tcc_presel_t active_q;
    logic [6:0] mask;

    assign mask = 7'((8'h01 << active_q) - 8'h01);
    assign tick_o = run_i & ((stage_q & mask) == mask);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage_q <= `TCC_PRE_ZERO;
        end else if (run_i) begin
            stage_q <= stage_q + `TCC_PRE_ONE;
        end
    end

    // New factor only where every stage is zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_q <= 3'h0;
        end else if (stage_q == `TCC_PRE_ZERO) begin
            active_q <= sel_i;
        end
    end
endmodule

// file: verif/tcc_core_assertions.sv
/* Port checker of the capture/compare timer core.
   Assumes binding to tcc_core; mirrors of written registers come from APB writes. */
`timescale 1ns/10ps
module tcc_core_chk #(
    parameter int CH_N = 8,
    parameter int CNT_W = 16,
    parameter int AW = 8
) (
    input wire logic mclk_i,                       // Clock
    input wire logic nrst_i,                       // Reset
    input wire logic psel_i,                       // APB
    input wire logic penable_i,                    // APB
    input wire logic pwrite_i,                     // APB
    input wire logic [AW-1:0] paddr_i,             // APB
    input wire tcc_pkg::tcc_word_t pwdata_i,       // APB
    input wire logic [3:0] pstrb_i,                // APB
    input wire tcc_pkg::tcc_word_t prdata_o,       // APB
    input wire logic pready_o,                     // APB
    input wire logic pslverr_o,                    // APB
    input wire logic [CH_N-1:0] chan_pin_i,        // Pins
    input wire logic [CH_N-1:0] compare_output_line_o, // Levels
    input wire logic [CH_N-1:0] compare_output_oe_o,   // Enables
    input wire logic [CH_N-1:0] chan_irq_o,        // Requests
    input wire logic ovf_irq_o                     // Request
);
    import tcc_pkg::*;
    wire logic acc = psel_i && penable_i;
    wire logic wr = acc && pwrite_i && pstrb_i[0];
    logic [7:0] ien_q, ios_q, act_nz;
    logic [15:0] act_q;
    logic toi_q;
    // Mirrors of enables and actions
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ien_q <= 8'h00;
            ios_q <= 8'h00;
            act_q <= 16'h0000;
            toi_q <= 1'b0;
        end else if (wr) begin
            if (paddr_i == 8'h30) ien_q <= pwdata_i[7:0];
            if (paddr_i == 8'h00) ios_q <= pwdata_i[7:0];
            if (paddr_i == 8'h20) act_q[15:8] <= pwdata_i[7:0];
            if (paddr_i == 8'h24) act_q[7:0] <= pwdata_i[7:0];
            if (paddr_i == 8'h34) toi_q <= pwdata_i[7];
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) act_nz[i] = |act_q[2*i+:2];
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    ready_in_access_a: assert property (acc |-> pready_o) else $error("ready low");
    err_only_access_a: assert property (!penable_i |-> !pslverr_o) else $error("early error");
    err_unaligned_a: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o)
        else $error("unaligned accepted");
    rdata_upper_a: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chan_irq_mask_a: assert property ((chan_irq_o & ~ien_q) == 8'h00) else $error("irq");
    ovf_irq_mask_a: assert property (ovf_irq_o |-> toi_q) else $error("ovf irq");
    drive_enable_a: assert property (compare_output_oe_o == (ios_q & act_nz)) else $error("oe");
    zero_keeps_flags_a: assert property (wr && paddr_i == 8'h38 && pwdata_i[7:0] == 8'h00 |=>
        (chan_irq_o & $past(chan_irq_o)) == $past(chan_irq_o)) else $error("flag lost");
    zero_keeps_ovf_a: assert property (wr && paddr_i == 8'h3c && !pwdata_i[7] |=>
        ovf_irq_o || !$past(ovf_irq_o)) else $error("ovf lost");
    quiet_after_reset_a: assert property ($rose(nrst_i) |->
        chan_irq_o == 8'h00 && !ovf_irq_o && compare_output_oe_o == 8'h00) else $error("not quiet");
    cover property (wr && paddr_i == 8'h38);
    cover property ($rose(ovf_irq_o));
    cover property ($rose(chan_irq_o[0]));
    cover property (acc && pslverr_o);
endmodule

bind tcc_core tcc_core_chk #(.CH_N(CH_N), .CNT_W(CNT_W), .AW(AW)) tcc_core_chk_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .chan_pin_i(chan_pin_i),
    .compare_output_line_o(compare_output_line_o), .compare_output_oe_o(compare_output_oe_o),
    .chan_irq_o(chan_irq_o), .ovf_irq_o(ovf_irq_o));

// file: verif/tcc_pin_model.sv
/* Signal sources on the channel pins.
   Assumes the bench requests levels; pins move just after a clock edge. */
`timescale 1ns/10ps
module tcc_pin_model (
    input wire logic mclk_i,       // Clock
    input wire logic [7:0] want_i, // Requested levels
    output logic [7:0] pin_o       // Pin levels
);
    initial pin_o = 8'h00;
    always @(posedge mclk_i) begin
        pin_o <= want_i;
    end
endmodule

// file: verif/tcc_core_tb_top.sv
/* Self-checking bench of the capture/compare timer core.
   Assumes tcc_core, its bound checker and tcc_pin_model. */
`timescale 1ns/10ps
module tcc_core_tb_top;
    import tcc_pkg::*;
    localparam logic [7:0] A_IOS = 8'h00, A_CNH = 8'h10, A_CT1 = 8'h18, A_ACL = 8'h24;
    localparam logic [7:0] A_EDL = 8'h2c, A_IEN = 8'h30, A_CT2 = 8'h34, A_CHF = 8'h38;
    localparam logic [7:0] A_OVF = 8'h3c;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, oirq, err;
    logic [7:0] paddr, want, pins, cline, coe, cirq, q;
    tcc_word_t pwdata, prdata;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    wire logic [8:0] ev = {oirq, cirq};

    tcc_core tcc_core_i (
        .mclk_i(mclk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .chan_pin_i(pins),
        .compare_output_line_o(cline), .compare_output_oe_o(coe), .chan_irq_o(cirq),
        .ovf_irq_o(oirq));
    tcc_pin_model tcc_pin_model_i (.mclk_i(mclk), .want_i(want), .pin_o(pins));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the access edge settle before callers look at outputs
        @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        apb(1'b0, a, 8'h00);
        v[15:8] = q;
        apb(1'b0, a + 8'h04, 8'h00);
        v[7:0] = q;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h04, v[7:0]);
    endtask

    task automatic wait_hi(input int i);
        for (int n = 0; n < 40 && ev[i] !== 1'b1; n++) @(negedge mclk);
    endtask

    initial begin
        logic [15:0] v, w;
        static logic [7:0] acts [4] = '{8'h03, 8'h02, 8'h01, 8'h00};
        static logic [3:0] lv = 4'hd;
        {psel, penable, pwrite, paddr, pwdata, want} = '0;
        nrst = 1'b0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            rd16(8'h40 + 8'(8 * n), v);
            check(v, 16'h0000);
        end
        apb(1'b0, 8'hfc, 8'h00);
        check({7'h00, err, q}, 16'h0100);
        wr(A_IEN, 8'ha5);
        apb(1'b0, A_IEN, 8'h00);
        check(16'(q), 16'h00a5);
        // Compare actions on channel 0
        wr(A_IOS, 8'h01);
        wr(A_IEN, 8'h01);
        wr(A_CT1, 8'h80);
        for (int k = 0; k < 4; k++) begin
            wr(A_ACL, acts[k]);
            wr(A_CHF, 8'hff);
            wr16(8'h40, 16'h1004);
            wr16(A_CNH, 16'h1000);
            wait_hi(0);
            check(16'(cirq[0]), 16'h0001);
            check({7'h00, coe[0], 7'h00, cline[0]}, {7'h00, 1'(k < 3), 7'h00, lv[k]});
        end
        wr(A_CHF, 8'h00);
        check(16'(cirq[0]), 16'h0001);
        wr(A_IEN, 8'h00);
        check(16'(cirq[0]), 16'h0000);
        wr(A_IEN, 8'h01);
        wr(A_CHF, 8'h01);
        check(16'(cirq[0]), 16'h0000);
        // Fast clearing
        wr(A_CT1, 8'h90);
        wr16(A_CNH, 16'h1000);
        wait_hi(0);
        wr(8'h44, 8'h04);
        check(16'(cirq[0]), 16'h0000);
        wr(A_CT2, 8'h80);
        wr16(A_CNH, 16'hfffc);
        wait_hi(8);
        check(16'(oirq), 16'h0001);
        apb(1'b0, A_CNH, 8'h00);
        check(16'(oirq), 16'h0000);
        wr(A_CT1, 8'h80);
        wr(A_CT2, 8'h00);
        wr16(A_CNH, 16'hfffc);
        repeat (20) @(posedge mclk);
        check(16'(oirq), 16'h0000);
        wr(A_CT2, 8'h80);
        wr(A_OVF, 8'h00);
        check(16'(oirq), 16'h0001);
        wr(A_OVF, 8'h80);
        check(16'(oirq), 16'h0000);
        // Counter reset on channel 7
        wr(A_IOS, 8'h81);
        wr(A_CT2, 8'h88);
        wr16(A_CNH, 16'h0000);
        repeat (20) @(posedge mclk);
        rd16(A_CNH, v);
        check(v, 16'h0000);
        wr16(8'h78, 16'h0020);
        repeat (100) @(posedge mclk);
        rd16(A_CNH, v);
        check(16'(v <= 16'h0020), 16'h0001);
        wr16(8'h78, 16'hffff);
        wr16(A_CNH, 16'hfff8);
        repeat (30) @(posedge mclk);
        check(16'(oirq), 16'h0000);
        for (int s = 0; s < 8; s++) begin
            wr(A_CT2, 8'(s));
            repeat (130) @(posedge mclk);
            rd16(A_CNH, v);
            repeat (256) @(posedge mclk);
            rd16(A_CNH, w);
            w = w - v - 16'(262 >> s);
            check(16'(w + 16'h0001 <= 16'h0002), 16'h0001);
        end
        wr(A_CT1, 8'h00);
        rd16(A_CNH, v);
        repeat (50) @(posedge mclk);
        rd16(A_CNH, w);
        check(w, v);
        // Capture on channel 1, timer stopped
        wr(A_IOS, 8'h00);
        wr(A_IEN, 8'h02);
        wr16(A_CNH, 16'h1234);
        for (int e = 0; e < 4; e++) begin
            wr(A_EDL, 8'(e << 2));
            wr(A_CHF, 8'hff);
            want <= 8'h02;
            repeat (8) @(posedge mclk);
            check(16'(cirq[1]), 16'(e[0]));
            wr(A_CHF, 8'hff);
            want <= 8'h00;
            repeat (8) @(posedge mclk);
            check(16'(cirq[1]), 16'(e[1]));
        end
        wr(A_CT1, 8'h10);
        rd16(8'h48, v);
        check(v, 16'h1234);
        check(16'(cirq[1]), 16'h0000);
        wr16(8'h48, 16'h5555);
        rd16(8'h48, v);
        check(v, 16'h1234);
        test_done();
    end
endmodule
